//--- logic/doc_cfg.svh
// Constants for the digital output channel selector: offsets, fields, resets, timing.
// Assumes it is included by bare name wherever a number is needed.
`ifndef DOC_CFG_SVH
`define DOC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets, one aligned 32-bit word each.
// ----------------------------------------------------------------------------
`define DOC_REG_CTRL     6'h00
`define DOC_REG_ON_DLY   6'h04
`define DOC_REG_OFF_DLY  6'h08
`define DOC_REG_WDOG     6'h0c
`define DOC_REG_STATUS   6'h10
`define DOC_REG_TYPE     6'h14
`define DOC_REG_INT_STAT 6'h18
`define DOC_REG_INT_MASK 6'h1c

// ----------------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------------
`define DOC_CTRL_SIM     0
`define DOC_CTRL_ERR_LO  1
`define DOC_CTRL_ERR_HI  2
`define DOC_CTRL_INV     3
`define DOC_CTRL_SUB     4
`define DOC_CTRL_SIMV    5
`define DOC_CTRL_SIMBAD  6
`define DOC_CTRL_W       7

// ----------------------------------------------------------------------------
// Interrupt bits: watchdog expiry, invalid data, line fault, output change.
// ----------------------------------------------------------------------------
`define DOC_INT_WDOG     0
`define DOC_INT_BAD      1
`define DOC_INT_FAULT    2
`define DOC_INT_TOGGLE   3
`define DOC_INT_W        4

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define DOC_CTRL_RST     7'h00
`define DOC_DLY_RST      16'h0000
`define DOC_WDOG_RST     16'h0000
`define DOC_MASK_RST     4'h0

// ----------------------------------------------------------------------------
// Timing: one millisecond at the system clock period.
// ----------------------------------------------------------------------------
`define DOC_MS_NS        1000000
`define DOC_CLK_NS       4
`define DOC_MS_CYCLES    (`DOC_MS_NS / `DOC_CLK_NS)

`endif

//--- logic/doc_pkg.sv
// Types shared by the digital output channel selector files.
// Assumes nothing beyond a SystemVerilog compiler.
package doc_pkg;

  // ----------------------------------------------------------------------------
  // Behaviour of the output while an error condition lasts.
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DOC_ERR_CURRENT = 2'b00,  // Keep the selected source value.
    DOC_ERR_SUBST   = 2'b01,  // Drive the configured substitute bit.
    DOC_ERR_LAST    = 2'b10   // Hold the last value driven before the fault.
  } doc_err_mode_t;

  // ----------------------------------------------------------------------------
  // Read-only channel type code.
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DOC_DIGITAL_INPUT_TYPE  = 2'b00,
    DOC_DIGITAL_OUTPUT_TYPE = 2'b01,
    DOC_ANALOG_INPUT_TYPE   = 2'b10,
    DOC_ANALOG_OUTPUT_TYPE  = 2'b11
  } doc_chan_type_t;

endpackage

//--- logic/doc_delay_filter.sv
// On/off delay filter for one digital output bit.
// Assumes a one-cycle millisecond tick on the same clock and static delay settings.
`timescale 1ns/1ps

module doc_delay_filter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ms_tick,
  input  wire logic        din,
  input  wire logic [15:0] on_ms,
  input  wire logic [15:0] off_ms,
  output logic             dout
);

  // ----------------------------------------------------------------------------
  // State and decode.
  // ----------------------------------------------------------------------------
  logic        q_q;    // Filtered output level.
  logic [15:0] cnt_q;  // Whole milliseconds the input has differed.

  wire         pend  = (din != q_q);          // Input wants a change.
  wire  [15:0] lim   = din ? on_ms : off_ms;  // Delay for this direction.
  wire         reach = (cnt_q >= lim);        // Delay used up.

  assign dout = q_q;

  // A change back before the delay runs out restarts the count, so short
  // pulses are swallowed by the on delay and short gaps by the off delay.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q   <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (!pend) begin
      cnt_q <= 16'h0000;
    end else if (reach) begin
      q_q   <= din;
      cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      cnt_q <= cnt_q + 16'h0001;  // Cannot wrap: cnt_q stays below lim here.
    end
  end

  // ----------------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------------
  property p_on_wait;
    @(posedge clk) disable iff (!rst_n) (!q_q && cnt_q < on_ms) |=> !q_q;
  endproperty
  a_on_wait: assert property (p_on_wait) else $error("output rose before on delay");

  property p_off_wait;
    @(posedge clk) disable iff (!rst_n) (q_q && cnt_q < off_ms) |=> q_q;
  endproperty
  a_off_wait: assert property (p_off_wait) else $error("output fell before off delay");

endmodule

//--- logic/doc_channel.sv
// Digital output channel selector with an Avalon-MM register slave.
// Assumes bus data, its update strobe and the module enable come from logic on clk;
// the line fault pin is asynchronous and is synchronised here.
`timescale 1ns/1ps

`include "doc_cfg.svh"

module doc_channel #(
  parameter int MS_CYCLES = `DOC_MS_CYCLES  // Clock cycles in one millisecond.
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bus_update,
  input  wire logic        bus_data,
  input  wire logic        bus_invalid,
  input  wire logic        module_enable,
  input  wire logic        line_fault_pin,
  output logic             chan_out,
  output logic             chan_active,
  output logic             chan_invalid,
  output logic             irq
);

  // ----------------------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------------------
  logic [`DOC_CTRL_W-1:0] ctrl_q;      // Mode, error mode, invert, values.
  logic [15:0]            on_ms_q;     // On delay in milliseconds.
  logic [15:0]            off_ms_q;    // Off delay in milliseconds.
  logic [15:0]            wdog_ms_q;   // Watchdog time, zero disables it.
  logic [`DOC_INT_W-1:0]  int_stat_q;  // Sticky event bits.
  logic [`DOC_INT_W-1:0]  int_mask_q;  // Interrupt enables.
  logic [`DOC_INT_W-1:0]  int_stat_d;  // Next sticky state.

  // ----------------------------------------------------------------------------
  // Bus side handshake: one wait cycle, then the access completes.
  // ----------------------------------------------------------------------------
  logic wait_q;  // Registered waitrequest, high until the access edge.

  wire req    = avs_read | avs_write;  // Any request present.
  wire snap   = req & wait_q;          // First cycle: read data captured.
  wire accept = req & ~wait_q;         // Edge at which the access completes.
  wire wr_acc = accept & avs_write;    // Write takes effect.
  wire rd_acc = accept & avs_read;     // Read completes.

  wire hit_ctrl  = (avs_address == `DOC_REG_CTRL);
  wire hit_on    = (avs_address == `DOC_REG_ON_DLY);
  wire hit_off   = (avs_address == `DOC_REG_OFF_DLY);
  wire hit_wdog  = (avs_address == `DOC_REG_WDOG);
  wire hit_stat  = (avs_address == `DOC_REG_STATUS);
  wire hit_type  = (avs_address == `DOC_REG_TYPE);
  wire hit_istat = (avs_address == `DOC_REG_INT_STAT);
  wire hit_imask = (avs_address == `DOC_REG_INT_MASK);

  assign avs_waitrequest = wait_q;

  // Toggle between wait and accept while a request is held.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~snap;
    end
  end

  // ----------------------------------------------------------------------------
  // Control field decode.
  // ----------------------------------------------------------------------------
  wire                   sim_mode = ctrl_q[`DOC_CTRL_SIM];
  wire                   invert   = ctrl_q[`DOC_CTRL_INV];
  wire                   sub_val  = ctrl_q[`DOC_CTRL_SUB];   // Single bit, 0 or 1.
  wire                   sim_val  = ctrl_q[`DOC_CTRL_SIMV];
  wire                   sim_bad  = ctrl_q[`DOC_CTRL_SIMBAD];
  wire doc_pkg::doc_err_mode_t err_mode =
    doc_pkg::doc_err_mode_t'(ctrl_q[`DOC_CTRL_ERR_HI:`DOC_CTRL_ERR_LO]);

  // ----------------------------------------------------------------------------
  // Millisecond tick divider.
  // ----------------------------------------------------------------------------
  logic [17:0] ms_cnt_q;  // Cycle counter within one millisecond.

  wire ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));

  // Free running so every delay and the watchdog share one time base.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 18'h00000;
    end else if (ms_tick) begin
      ms_cnt_q <= 18'h00000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 18'h00001;
    end
  end

  // ----------------------------------------------------------------------------
  // Received bus value and communication watchdog.
  // ----------------------------------------------------------------------------
  logic        bus_val_q;   // Last value written by the controller.
  logic        bus_bad_q;   // Its status flag, high for invalid data.
  logic [15:0] wdog_cnt_q;  // Milliseconds since the last update.
  logic        wdog_exp_q;  // Watchdog has run out.

  wire wdog_hit = (wdog_ms_q != 16'h0000) && (wdog_cnt_q >= wdog_ms_q);

  // Latch each update; the watchdog restarts on every update strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_val_q  <= 1'b0;
      bus_bad_q  <= 1'b0;
      wdog_cnt_q <= 16'h0000;
      wdog_exp_q <= 1'b0;
    end else if (bus_update) begin
      bus_val_q  <= bus_data;
      bus_bad_q  <= bus_invalid;
      wdog_cnt_q <= 16'h0000;
      wdog_exp_q <= 1'b0;
    end else begin
      if (ms_tick && !wdog_hit) begin
        wdog_cnt_q <= wdog_cnt_q + 16'h0001;
      end
      wdog_exp_q <= wdog_hit;
    end
  end

  // ----------------------------------------------------------------------------
  // Line fault pin: two flip-flops, then only reported, never used for selection.
  // ----------------------------------------------------------------------------
  logic fault_m_q;  // First stage, read by the second stage only.
  logic fault_s_q;  // Synchronised line fault level.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_m_q <= 1'b0;
      fault_s_q <= 1'b0;
    end else begin
      fault_m_q <= line_fault_pin;
      fault_s_q <= fault_m_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Source selection and error strategy.
  // ----------------------------------------------------------------------------
  logic last_q;  // Last value selected while no error was present.

  // Simulation replaces the bus value and its status.
  wire src     = sim_mode ? sim_val : bus_val_q;
  wire src_bad = sim_mode ? sim_bad : bus_bad_q;
  // The fault pin is deliberately absent from the error term.
  wire err     = wdog_exp_q | src_bad;

  wire use_cur = (err_mode == doc_pkg::DOC_ERR_CURRENT);
  wire use_lst = (err_mode == doc_pkg::DOC_ERR_LAST);
  // The unused code 2'b11 behaves as substitute, the safe choice.
  wire err_val = use_cur ? src : (use_lst ? last_q : sub_val);
  wire sel     = err ? err_val : src;
  wire sel_bad = err;

  // Inversion sits after selection and before the delay filter.
  wire pre_dly = sel ^ invert;

  // Remember the last good value so hold-last survives a long fault.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
    end else if (!err) begin
      last_q <= src;
    end
  end

  // ----------------------------------------------------------------------------
  // Delay filter and output registers.
  // ----------------------------------------------------------------------------
  logic filt;  // Delayed level.

  doc_delay_filter u_filter (
    .clk     (clk),
    .rst_n   (rst_n),
    .ms_tick (ms_tick),
    .din     (pre_dly),
    .on_ms   (on_ms_q),
    .off_ms  (off_ms_q),
    .dout    (filt)
  );

  // An inactive channel drives low, so a disabled module leaves the pin off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_out     <= 1'b0;
      chan_active  <= 1'b0;
      chan_invalid <= 1'b0;
    end else begin
      chan_out     <= module_enable & filt;
      chan_active  <= module_enable;
      chan_invalid <= sel_bad;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt events, rising edges of each condition, both edges of the output level.
  // ----------------------------------------------------------------------------
  logic                  exp_p_q;    // Previous watchdog state.
  logic                  bad_p_q;    // Previous invalid state.
  logic                  fault_p_q;  // Previous fault level.
  logic                  out_p_q;    // Previous output level.
  logic [`DOC_INT_W-1:0] events;     // One-cycle event pulses.
  logic [`DOC_INT_W-1:0] int_clr;    // Bits removed by a status read.

  assign events[`DOC_INT_WDOG]   = wdog_exp_q & ~exp_p_q;
  assign events[`DOC_INT_BAD]    = src_bad & ~bad_p_q;
  assign events[`DOC_INT_FAULT]  = fault_s_q & ~fault_p_q;
  assign events[`DOC_INT_TOGGLE] = chan_out ^ out_p_q;

  // Only bits the reader actually saw are cleared, and a new event wins.
  assign int_clr    = (rd_acc & hit_istat) ? avs_readdata[`DOC_INT_W-1:0] : 4'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | events;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_p_q    <= 1'b0;
      bad_p_q    <= 1'b0;
      fault_p_q  <= 1'b0;
      out_p_q    <= 1'b0;
      int_stat_q <= 4'h0;
      irq        <= 1'b0;
    end else begin
      exp_p_q    <= wdog_exp_q;
      bad_p_q    <= src_bad;
      fault_p_q  <= fault_s_q;
      out_p_q    <= chan_out;
      int_stat_q <= int_stat_d;
      irq        <= |(int_stat_d & int_mask_q);
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes, taken only at the access edge.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= `DOC_CTRL_RST;
      on_ms_q    <= `DOC_DLY_RST;
      off_ms_q   <= `DOC_DLY_RST;
      wdog_ms_q  <= `DOC_WDOG_RST;
      int_mask_q <= `DOC_MASK_RST;
    end else if (wr_acc) begin
      if (hit_ctrl)  ctrl_q     <= avs_writedata[`DOC_CTRL_W-1:0];
      if (hit_on)    on_ms_q    <= avs_writedata[15:0];
      if (hit_off)   off_ms_q   <= avs_writedata[15:0];
      if (hit_wdog)  wdog_ms_q  <= avs_writedata[15:0];
      if (hit_imask) int_mask_q <= avs_writedata[`DOC_INT_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Read data, captured in the wait cycle so it stands at the access edge.
  // ----------------------------------------------------------------------------
  wire [5:0]  stat_bits = {sel_bad & ~use_cur, fault_s_q, wdog_exp_q,
                           chan_invalid, chan_active, chan_out};
  wire [31:0] rd_mux =
    hit_ctrl  ? {25'h0000000, ctrl_q} :
    hit_on    ? {16'h0000, on_ms_q} :
    hit_off   ? {16'h0000, off_ms_q} :
    hit_wdog  ? {16'h0000, wdog_ms_q} :
    hit_stat  ? {26'h0000000, stat_bits} :
    hit_type  ? {30'h00000000, doc_pkg::DOC_DIGITAL_OUTPUT_TYPE} :
    hit_istat ? {28'h0000000, int_stat_q} :
    hit_imask ? {28'h0000000, int_mask_q} :
    32'h00000000;  // Unmapped words read zero.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (snap && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------------
  property p_normal;
    @(posedge clk) disable iff (!rst_n) (!sim_mode && !err) |-> (sel == bus_val_q);
  endproperty
  a_normal: assert property (p_normal) else $error("bus value not selected");

  property p_sim;
    @(posedge clk) disable iff (!rst_n) (sim_mode && !err) |-> (sel == sim_val);
  endproperty
  a_sim: assert property (p_sim) else $error("simulation value not selected");

  property p_wdog;
    @(posedge clk) disable iff (!rst_n)
      (!bus_update && wdog_hit) |=> (err && wdog_exp_q);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog expiry missed");

  property p_bad;
    @(posedge clk) disable iff (!rst_n)
      (bus_update && bus_invalid && !sim_mode) |=> (err || sim_mode);
  endproperty
  a_bad: assert property (p_bad) else $error("invalid bus data not flagged");

  property p_no_fault;
    @(posedge clk) disable iff (!rst_n)
      (fault_s_q && !wdog_exp_q && !src_bad) |=> !chan_invalid;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("error without cause");

  property p_current;
    @(posedge clk) disable iff (!rst_n) (err && use_cur) |-> (sel == src);
  endproperty
  a_current: assert property (p_current) else $error("current value not kept");

  property p_subst;
    @(posedge clk) disable iff (!rst_n)
      (err && err_mode == doc_pkg::DOC_ERR_SUBST) |-> (sel == sub_val) ##1 chan_invalid;
  endproperty
  a_subst: assert property (p_subst) else $error("substitute not driven");

  property p_last;
    @(posedge clk) disable iff (!rst_n)
      (err && use_lst && $past(err) && $past(use_lst)) |-> (sel == $past(sel));
  endproperty
  a_last: assert property (p_last) else $error("last value not held");

  property p_invert;
    @(posedge clk) disable iff (!rst_n) (pre_dly != sel) == invert;
  endproperty
  a_invert: assert property (p_invert) else $error("inversion wrong");

  property p_active;
    @(posedge clk) disable iff (!rst_n)
      $changed(module_enable) |=> (chan_active == $past(module_enable));
  endproperty
  a_active: assert property (p_active) else $error("active does not follow enable");

  property p_type;
    @(posedge clk) disable iff (!rst_n)
      (rd_acc && hit_type) |-> (avs_readdata == 32'h00000001);
  endproperty
  a_type: assert property (p_type) else $error("channel type wrong");

  property p_sim_bad;
    @(posedge clk) disable iff (!rst_n) (sim_mode && sim_bad) |-> err;
  endproperty
  a_sim_bad: assert property (p_sim_bad) else $error("bad simulation status ignored");

endmodule

//--- tb/doc_com_model.sv
// Model of the com unit logic that hands bus values to the channel.
// Assumes the same clock as the channel; tasks are called right after an edge.
`timescale 1ns/1ps

module doc_com_model (
  input  wire logic clk,
  output logic      bus_update,
  output logic      bus_data,
  output logic      bus_invalid
);
  // -------------------------------------------------
  // Idle state: no strobe, data lines not qualified.
  // -------------------------------------------------
  initial begin
    bus_update  = 1'b0;
    bus_data    = 1'b0;
    bus_invalid = 1'b0;
  end

  // Sends one value with its status as a one-cycle strobe.
  // Afterwards the lines show the inverse, so a stale value is never mistaken for a live one.
  task automatic send(input logic d, input logic inv);
    @(posedge clk);
    bus_update  <= 1'b1;
    bus_data    <= d;
    bus_invalid <= inv;
    @(posedge clk);
    bus_update  <= 1'b0;
    bus_data    <= ~d;
    bus_invalid <= ~inv;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the digital output channel selector.
// Assumes a 250 MHz clock and a millisecond shortened to 10 cycles.
`timescale 1ns/1ps
`include "doc_cfg.svh"

module tb_top;
  logic clk, rst_n, rd_q, wr_q, bus_update, bus_data, bus_invalid;
  logic module_enable, line_fault_pin, chan_out, chan_active, chan_invalid, irq;
  logic [5:0]  addr_q;
  logic [31:0] wdata_q, avs_readdata;
  logic        avs_waitrequest;
  logic [63:0] exp_q[$];  // Expected read results as {mask, value}.
  integer      n_errors, n_checks, seed;

  doc_channel #(.MS_CYCLES(10)) u_doc_channel (.clk(clk), .rst_n(rst_n),
    .avs_address(addr_q), .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wdata_q),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_update(bus_update), .bus_data(bus_data), .bus_invalid(bus_invalid),
    .module_enable(module_enable), .line_fault_pin(line_fault_pin),
    .chan_out(chan_out), .chan_active(chan_active), .chan_invalid(chan_invalid), .irq(irq));
  doc_com_model u_doc_com_model (.clk(clk), .bus_update(bus_update),
    .bus_data(bus_data), .bus_invalid(bus_invalid));

  // ------------------------------------------
  // Helpers: compare, bus access, waits.
  // ------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Holds the request until waitrequest is seen low at an edge, then releases it.
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_q <= w;
    rd_q <= ~w;
    addr_q <= a;
    wdata_q <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);  // Only the watchdog ends a hang.
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
    acc(1'b0, a, 32'h0);
  endtask
  task automatic st(input logic [5:0] v);  // Settle, then read the status word.
    cyc(8);
    chk({29'h0, chan_invalid, chan_active, chan_out}, {29'h0, v[2:0]}, "pins");
    rd(`DOC_REG_STATUS, 32'h3f, {26'h0, v});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Monitor: each completed read takes the oldest expectation off the queue.
  always @(posedge clk) begin
    logic [63:0] e;
    if (rd_q === 1'b1 && avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      chk(avs_readdata & e[63:32], e[31:0], "readdata");
    end
  end

  // -------------------------------
  // Clock, watchdog and stimulus.
  // -------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    cyc(20000);  // Far beyond the few hundred cycles the tests need.
    n_errors++;
    final_report();
  end
  initial begin
    {rd_q, wr_q, addr_q, wdata_q, module_enable, line_fault_pin} = '0;
    n_errors = 0;
    n_checks = 0;
    seed = 32'he2e78d36;
    rst_n = 1'b0;
    cyc(6);
    rst_n <= 1'b1;
    rd(`DOC_REG_CTRL, 32'hffffffff, 32'h0);
    rd(6'h24, 32'hffffffff, 32'h0);  // Unmapped word reads zero.
    acc(1'b1, `DOC_REG_TYPE, 32'h0);
    rd(`DOC_REG_TYPE, 32'hffffffff, 32'h1);
    $display("test done: reset and map");
    module_enable <= 1'b1;
    repeat (4) begin : rnd
      logic d;
      d = 1'($random(seed));
      u_doc_com_model.send(d, 1'b0);
      st({5'b00001, d});
    end
    u_doc_com_model.send(1'b1, 1'b0);
    line_fault_pin <= 1'b1;
    st(6'b010011);
    line_fault_pin <= 1'b0;
    acc(1'b1, `DOC_REG_CTRL, 32'h08);
    st(6'b000010);
    acc(1'b1, `DOC_REG_CTRL, 32'h01);
    st(6'b000010);
    acc(1'b1, `DOC_REG_CTRL, 32'h61);
    st(6'b000111);
    acc(1'b1, `DOC_REG_CTRL, 32'h63);
    st(6'b100110);
    $display("test done: source selection");
    acc(1'b1, `DOC_REG_CTRL, 32'h04);
    u_doc_com_model.send(1'b0, 1'b1);
    st(6'b100111);
    acc(1'b1, `DOC_REG_CTRL, 32'h06);
    st(6'b100110);
    acc(1'b1, `DOC_REG_CTRL, 32'h00);
    st(6'b000110);
    u_doc_com_model.send(1'b0, 1'b0);
    rd(`DOC_REG_INT_STAT, 32'h0, 32'h0);  // Clear old events, value not judged.
    acc(1'b1, `DOC_REG_WDOG, 32'h2);
    acc(1'b1, `DOC_REG_CTRL, 32'h1a);
    cyc(40);
    st(6'b101110);
    acc(1'b1, `DOC_REG_INT_MASK, 32'h1);
    cyc(4);
    chk(irq, 32'h1, "irq");
    rd(`DOC_REG_INT_STAT, 32'h1, 32'h1);
    cyc(4);
    chk(irq, 32'h0, "irq");
    acc(1'b1, `DOC_REG_WDOG, 32'h0);
    $display("test done: errors and interrupt");
    acc(1'b1, `DOC_REG_CTRL, 32'h00);
    u_doc_com_model.send(1'b0, 1'b0);
    acc(1'b1, `DOC_REG_ON_DLY, 32'h3);
    acc(1'b1, `DOC_REG_OFF_DLY, 32'h3);
    u_doc_com_model.send(1'b1, 1'b0);
    cyc(10);
    u_doc_com_model.send(1'b0, 1'b0);
    cyc(50);
    rd(`DOC_REG_STATUS, 32'h1, 32'h0);
    u_doc_com_model.send(1'b1, 1'b0);
    cyc(50);
    rd(`DOC_REG_STATUS, 32'h1, 32'h1);
    u_doc_com_model.send(1'b0, 1'b0);
    cyc(8);
    rd(`DOC_REG_STATUS, 32'h1, 32'h1);
    cyc(50);
    rd(`DOC_REG_STATUS, 32'h1, 32'h0);
    module_enable <= 1'b0;
    st(6'b000000);
    $display("test done: delays and enable");
    cyc(4);
    final_report();
  end
endmodule
